// [rtl/tft_sync_display_port.v]
// Colour panel output port: timing generator, pixel narrowing and
// a small register file on a plain strobe port.
// Assumes the pixel stream is on core_clk_i and holds a pixel until
// pix_taken_o; the pixel clock arrives from outside and is resampled.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "tft_port_consts.vh"
module tft_sync_display_port #(
    parameter CNT_W = 12
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [3:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    output reg [15:0] reg_rdata_o,
    input wire [31:0] pix_data_i,
    input wire pix_valid_i,
    output reg pix_taken_o,
    input wire panel_pixel_clock_i,
    output reg pixel_clock_pin_o,
    output reg line_sync_pin_o,
    output reg line_sync_oe_o,
    output reg frame_sync_pin_o,
    output reg frame_sync_oe_o,
    output reg data_valid_pin_o,
    output reg [23:0] colour_bus_o,
    output reg [23:0] colour_bus_oe_o
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rst_meta;
    reg rst_sync;
    wire rst_n;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rst_n = rst_sync;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [15:0] ctrl;
    reg [CNT_W-1:0] h_active;
    reg [CNT_W-1:0] h_back;
    reg [CNT_W-1:0] h_front;
    reg [CNT_W-1:0] h_sync;
    reg [CNT_W-1:0] v_active;
    reg [CNT_W-1:0] v_back;
    reg [CNT_W-1:0] v_front;
    reg [CNT_W-1:0] v_sync;
    reg underrun;
    reg [CNT_W-1:0] h_pos;
    reg [CNT_W-1:0] v_pos;

    wire enable = ctrl[`CTRL_ENABLE];
    wire [1:0] panel_class = ctrl[`CTRL_CLASS_HI:`CTRL_CLASS_LO];
    wire line_pol = ctrl[`CTRL_LINE_POL];
    wire frame_pol = ctrl[`CTRL_FRAME_POL];
    wire clk_pol = ctrl[`CTRL_CLK_POL];
    wire sync_use = ctrl[`CTRL_SYNC_USE];
    wire [1:0] link_sel = ctrl[`CTRL_LINK_HI:`CTRL_LINK_LO];
    wire [1:0] fmt_sel = ctrl[`CTRL_FMT_HI:`CTRL_FMT_LO];
    // Other classes exist in the controller but leave this port idle
    wire bad_class = (panel_class != `CLASS_COLOUR);
    wire running = enable & ~bad_class;

    function [15:0] widen;
        input [CNT_W-1:0] value;
        begin
            widen = 16'h0000;
            widen[CNT_W-1:0] = value;
        end
    endfunction

    reg frame_sync_level;
    reg de_level;
    wire [3:0] status = {bad_class, frame_sync_level, de_level, underrun};

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `RST_CTRL;
            h_active <= `RST_H_ACTIVE;
            h_back <= `RST_H_BACK;
            h_front <= `RST_H_FRONT;
            h_sync <= `RST_H_SYNC;
            v_active <= `RST_V_ACTIVE;
            v_back <= `RST_V_BACK;
            v_front <= `RST_V_FRONT;
            v_sync <= `RST_V_SYNC;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                `REG_CTRL: ctrl <= reg_wdata_i;
                `REG_H_ACTIVE: h_active <= reg_wdata_i[CNT_W-1:0];
                `REG_H_BACK: h_back <= reg_wdata_i[CNT_W-1:0];
                `REG_H_FRONT: h_front <= reg_wdata_i[CNT_W-1:0];
                `REG_H_SYNC: h_sync <= reg_wdata_i[CNT_W-1:0];
                `REG_V_ACTIVE: v_active <= reg_wdata_i[CNT_W-1:0];
                `REG_V_BACK: v_back <= reg_wdata_i[CNT_W-1:0];
                `REG_V_FRONT: v_front <= reg_wdata_i[CNT_W-1:0];
                `REG_V_SYNC: v_sync <= reg_wdata_i[CNT_W-1:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                `REG_CTRL: reg_rdata_o <= ctrl;
                `REG_H_ACTIVE: reg_rdata_o <= widen(h_active);
                `REG_H_BACK: reg_rdata_o <= widen(h_back);
                `REG_H_FRONT: reg_rdata_o <= widen(h_front);
                `REG_H_SYNC: reg_rdata_o <= widen(h_sync);
                `REG_V_ACTIVE: reg_rdata_o <= widen(v_active);
                `REG_V_BACK: reg_rdata_o <= widen(v_back);
                `REG_V_FRONT: reg_rdata_o <= widen(v_front);
                `REG_V_SYNC: reg_rdata_o <= widen(v_sync);
                `REG_STATUS: reg_rdata_o <= {12'h000, status};
                `REG_H_POS: reg_rdata_o <= widen(h_pos);
                `REG_V_POS: reg_rdata_o <= widen(v_pos);
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Pixel clock sampling and update edge
    // ------------------------------------------------------------
    wire pclk_level;
    wire pclk_rise;
    wire pclk_fall;

    link_clock_sampler u_sampler (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .link_clk_i(panel_pixel_clock_i),
        .level_o(pclk_level),
        .rise_o(pclk_rise),
        .fall_o(pclk_fall)
    );

    // Bus moves half a pixel clock before the panel samples it
    wire update = clk_pol ? pclk_fall : pclk_rise;

    // ------------------------------------------------------------
    // Pixel and line counters
    // ------------------------------------------------------------
    // Sync widths sit inside the back porches, so the totals
    // are porch plus active plus porch
    wire [CNT_W-1:0] h_total = h_back + h_active + h_front;
    wire [CNT_W-1:0] v_total = v_back + v_active + v_front;
    wire h_last = (h_pos >= h_total - 1'b1);
    wire v_last = (v_pos >= v_total - 1'b1);
    reg [CNT_W-1:0] next_h_pos;
    reg [CNT_W-1:0] next_v_pos;

    always @* begin
        next_h_pos = h_pos;
        next_v_pos = v_pos;
        if (!running) begin
            next_h_pos = {CNT_W{1'b0}};
            next_v_pos = {CNT_W{1'b0}};
        end else if (update) begin
            if (h_last) begin
                next_h_pos = {CNT_W{1'b0}};
                next_v_pos = v_last ? {CNT_W{1'b0}}
                                    : v_pos + 1'b1;
            end else begin
                next_h_pos = h_pos + 1'b1;
            end
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            h_pos <= {CNT_W{1'b0}};
            v_pos <= {CNT_W{1'b0}};
        end else begin
            h_pos <= next_h_pos;
            v_pos <= next_v_pos;
        end
    end

    // ------------------------------------------------------------
    // Sync and enable decode for the position about to be shown
    // ------------------------------------------------------------
    // Line sync opens each line; its width counts within back porch
    wire next_line_act = running
        & (next_h_pos < h_sync);
    // Frame sync opens the frame; the back porch starts with it
    wire next_frame_act = running
        & (next_v_pos < v_sync);
    wire next_h_vis = (next_h_pos >= h_back)
        & (next_h_pos < h_back + h_active);
    wire next_v_vis = (next_v_pos >= v_back)
        & (next_v_pos < v_back + v_active);
    wire next_de = running & next_h_vis & next_v_vis;

    wire [23:0] narrow_colour;

    pixel_narrow u_narrow (
        .pixel_i(pix_data_i),
        .format_i(fmt_sel),
        .link_i(link_sel),
        .colour_o(narrow_colour)
    );

    function [23:0] link_mask;
        input [1:0] sel;
        begin
            case (sel)
                `LINK_18: link_mask = 24'h03ffff;
                `LINK_16: link_mask = 24'h00ffff;
                default: link_mask = 24'hffffff;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Pin drivers; while running, syncs, data valid and colour change only on the update edge
    // ------------------------------------------------------------
    wire take = update & next_de;

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pixel_clock_pin_o <= 1'b0;
            line_sync_pin_o <= 1'b0;
            frame_sync_pin_o <= 1'b0;
            line_sync_oe_o <= 1'b0;
            frame_sync_oe_o <= 1'b0;
            data_valid_pin_o <= 1'b0;
            colour_bus_o <= 24'h000000;
            colour_bus_oe_o <= 24'h000000;
            pix_taken_o <= 1'b0;
            de_level <= 1'b0;
            frame_sync_level <= 1'b0;
        end else begin
            // Pin copy shares the sampling delay with the bus
            pixel_clock_pin_o <= running & (pclk_level ^ pclk_rise ^ pclk_fall);
            // Unused sync and colour lines are released to other uses
            line_sync_oe_o <= running & sync_use;
            frame_sync_oe_o <= running & sync_use;
            colour_bus_oe_o <= running ? link_mask(link_sel)
                                       : 24'h000000;
            pix_taken_o <= take;
            if (!running) begin
                line_sync_pin_o <= 1'b0;
                frame_sync_pin_o <= 1'b0;
                data_valid_pin_o <= 1'b0;
                colour_bus_o <= 24'h000000;
                de_level <= 1'b0;
                frame_sync_level <= 1'b0;
            end else if (update) begin
                // Polarity bit gives the asserted level directly
                line_sync_pin_o <= ~(next_line_act
                    ^ line_pol);
                frame_sync_pin_o <= ~(next_frame_act
                    ^ frame_pol);
                data_valid_pin_o <= next_de;
                de_level <= next_de;
                frame_sync_level <= next_frame_act;
                // Blanking shows zeros; panel ignores them anyway
                colour_bus_o <= next_de
                    ? (narrow_colour & link_mask(link_sel))
                    : 24'h000000;
            end
        end
    end

    // ------------------------------------------------------------
    // Underrun flag: a missing pixel is still clocked out
    // ------------------------------------------------------------
    wire clear_underrun = reg_write_i & (reg_addr_i == `REG_STATUS)
        & reg_wdata_i[`STAT_UNDERRUN];

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            underrun <= 1'b0;
        end else if (take & ~pix_valid_i) begin
            // A new event outranks a clear in the same cycle
            underrun <= 1'b1;
        end else if (clear_underrun) begin
            underrun <= 1'b0;
        end
    end
endmodule

// [rtl/tft_port_consts.vh]
// Constants of the colour panel output port: register map, control
// field positions, reset values and the pixel clock timing figures.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef TFT_PORT_CONSTS_VH
`define TFT_PORT_CONSTS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_H_ACTIVE 4'h1
`define REG_H_BACK 4'h2
`define REG_H_FRONT 4'h3
`define REG_H_SYNC 4'h4
`define REG_V_ACTIVE 4'h5
`define REG_V_BACK 4'h6
`define REG_V_FRONT 4'h7
`define REG_V_SYNC 4'h8
`define REG_STATUS 4'h9
`define REG_H_POS 4'ha
`define REG_V_POS 4'hb

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_CLASS_LO 1
`define CTRL_CLASS_HI 2
`define CTRL_LINE_POL 3
`define CTRL_FRAME_POL 4
`define CTRL_CLK_POL 5
`define CTRL_SYNC_USE 6
`define CTRL_LINK_LO 7
`define CTRL_LINK_HI 8
`define CTRL_FMT_LO 9
`define CTRL_FMT_HI 10

`define CLASS_MONO 2'h0
`define CLASS_COLOUR 2'h1
`define CLASS_YUV_PROG 2'h2
`define CLASS_YUV_INTL 2'h3

`define LINK_24 2'h0
`define LINK_18 2'h1
`define LINK_16 2'h2

`define FMT_565 2'h0
`define FMT_666 2'h1
`define FMT_888 2'h2
`define FMT_8888 2'h3

`define STAT_UNDERRUN 0
`define STAT_ACTIVE 1
`define STAT_FRAME 2
`define STAT_BAD_CLASS 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL 16'h0043
`define RST_H_ACTIVE 12'h280
`define RST_H_BACK 12'h030
`define RST_H_FRONT 12'h010
`define RST_H_SYNC 12'h002
`define RST_V_ACTIVE 12'h1e0
`define RST_V_BACK 12'h022
`define RST_V_FRONT 12'h00b
`define RST_V_SYNC 12'h001

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CORE_CLK_PERIOD_NS 25
`define PIXEL_CLK_PERIOD_NS 200
`define CORE_PER_PIXEL (`PIXEL_CLK_PERIOD_NS / `CORE_CLK_PERIOD_NS)

`endif

// [rtl/link_clock_sampler.v]
// Samples the incoming pixel clock in the core clock domain.
// Assumes the pixel clock is slower than half the core clock rate.
`timescale 1ns/1ps
module link_clock_sampler (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire link_clk_i,
    output reg level_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta;
    reg sync;

    // ------------------------------------------------------------
    // Two-stage synchroniser, then one stage for edge finding
    // ------------------------------------------------------------
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            level_o <= 1'b0;
        end else begin
            meta <= link_clk_i;
            sync <= meta;
            level_o <= sync;
        end
    end

    assign rise_o = sync & ~level_o;
    assign fall_o = ~sync & level_o;
endmodule

// [rtl/pixel_narrow.v]
// Maps one internal pixel onto the selected link width.
// Assumes pixels are packed red high, blue low, alpha above red.
`timescale 1ns/1ps
`include "tft_port_consts.vh"
module pixel_narrow (
    input wire [31:0] pixel_i,
    input wire [1:0] format_i,
    input wire [1:0] link_i,
    output reg [23:0] colour_o
);
    reg [7:0] red;
    reg [7:0] green;
    reg [7:0] blue;

    // ------------------------------------------------------------
    // Left-align components, then drop low bits for the link
    // ------------------------------------------------------------
    always @* begin
        red = 8'h00;
        green = 8'h00;
        blue = 8'h00;
        case (format_i)
            `FMT_565: begin
                red = {pixel_i[15:11], 3'h0};
                green = {pixel_i[10:5], 2'h0};
                blue = {pixel_i[4:0], 3'h0};
            end
            `FMT_666: begin
                red = {pixel_i[17:12], 2'h0};
                green = {pixel_i[11:6], 2'h0};
                blue = {pixel_i[5:0], 2'h0};
            end
            default: begin
                // Alpha byte of 8888 is never sent
                red = pixel_i[23:16];
                green = pixel_i[15:8];
                blue = pixel_i[7:0];
            end
        endcase
        // Plain truncation; no dithering trades smoothness for exactness
        case (link_i)
            `LINK_18: colour_o = {6'h00, red[7:2], green[7:2],
                                  blue[7:2]};
            `LINK_16: colour_o = {8'h00, red[7:3], green[7:2],
                                  blue[7:3]};
            default: colour_o = {red, green, blue};
        endcase
    end
endmodule

// [bench/tft_port_checker_sva.sv]
// Checker for the colour panel port, seeing only the top module's ports.
// Assumes the timing registers are invisible, so checks are relational.
`timescale 1ns/1ps
module tft_port_checker (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire pix_taken_o,
    input wire pixel_clock_pin_o,
    input wire line_sync_oe_o,
    input wire frame_sync_oe_o,
    input wire data_valid_pin_o,
    input wire [23:0] colour_bus_o,
    input wire [23:0] colour_bus_oe_o
);
    default clocking cb
        @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_de_start;
        $rose(data_valid_pin_o);
    endsequence
    sequence s_taken_once;
        pix_taken_o ##1 !pix_taken_o;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_idle_colour;
        !data_valid_pin_o |-> colour_bus_o == 24'h0;
    endproperty
    property p_taken_cause;
        pix_taken_o |-> data_valid_pin_o;
    endproperty
    property p_first_taken;
        s_de_start |-> s_taken_once;
    endproperty
    // Gap of six only: the sampled clock may jitter by a cycle
    property p_taken_gap;
        pix_taken_o |=> !pix_taken_o [*6];
    endproperty
    property p_bus_on_edge;
        data_valid_pin_o && $changed(colour_bus_o)
            |-> $changed(pixel_clock_pin_o);
    endproperty
    property p_de_on_edge;
        s_de_start |-> $changed(pixel_clock_pin_o);
    endproperty
    property p_oe_code;
        colour_bus_oe_o inside {24'h0, 24'h00ffff, 24'h03ffff, 24'hffffff};
    endproperty
    property p_sync_oe_pair;
        line_sync_oe_o == frame_sync_oe_o;
    endproperty
    property p_de_needs_oe;
        data_valid_pin_o |-> colour_bus_oe_o != 24'h0;
    endproperty

    a_idle_colour: assert property (p_idle_colour)
        else $error("colour bus not idle outside data enable");
    a_taken_cause: assert property (p_taken_cause)
        else $error("pixel taken without data enable");
    a_first_taken: assert property (p_first_taken)
        else $error("first pixel of line not taken");
    a_taken_gap: assert property (p_taken_gap)
        else $error("two pixels taken in one pixel period");
    a_bus_on_edge: assert property (p_bus_on_edge)
        else $error("colour changed away from a pixel clock edge");
    a_de_on_edge: assert property (p_de_on_edge)
        else $error("data enable rose away from a pixel clock edge");
    a_oe_code: assert property (p_oe_code)
        else $error("colour enable mask is not a link width");
    a_sync_oe_pair: assert property (p_sync_oe_pair)
        else $error("sync enables disagree");
    a_de_needs_oe: assert property (p_de_needs_oe)
        else $error("data enable while colour lines released");
endmodule

bind tft_sync_display_port tft_port_checker chk_u (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pix_taken_o(pix_taken_o),
    .pixel_clock_pin_o(pixel_clock_pin_o),
    .line_sync_oe_o(line_sync_oe_o),
    .frame_sync_oe_o(frame_sync_oe_o),
    .data_valid_pin_o(data_valid_pin_o),
    .colour_bus_o(colour_bus_o),
    .colour_bus_oe_o(colour_bus_oe_o)
);

// [bench/panel_model.sv]
// Behavioural colour panel: latches pixels, counts lines and frames.
// Assumes its pins are sampled on the core clock, fast enough for them.
`timescale 1ns/1ps
module panel_model (
    input wire clk_i,
    input wire pclk_i,
    input wire ls_i,
    input wire fs_i,
    input wire de_i,
    input wire [23:0] d_i,
    input wire cpol_i,
    input wire lpol_i,
    input wire fpol_i,
    input wire seq_i,
    output integer n_px,
    output reg [23:0] last_px,
    output integer line_px,
    output integer frame_lines,
    output integer n_frames,
    output integer n_bad
);
    reg pc_d = 1'b0;
    reg ls_d = 1'b0;
    reg fs_d = 1'b0;
    reg has = 1'b0;
    reg [23:0] d_d = 24'h0;
    integer px = 0;
    integer ln = 0;
    // Latch on rising edge for high polarity, falling for low
    wire latch = (pclk_i != pc_d) && (pclk_i == cpol_i);
    wire ls_on = (ls_i == lpol_i) && (ls_d != lpol_i);
    wire fs_on = (fs_i == fpol_i) && (fs_d != fpol_i);
    wire stale = d_i != d_d;
    wire sync_on = (ls_i == lpol_i) || (fs_i == fpol_i);
    wire jump = seq_i && has && (d_i != last_px + 24'h010101);

    initial begin
        n_px = 0;
        last_px = 24'h0;
        line_px = 0;
        frame_lines = 0;
        n_frames = 0;
        n_bad = 0;
    end

    always @(posedge clk_i) begin
        pc_d <= pclk_i;
        ls_d <= ls_i;
        fs_d <= fs_i;
        d_d <= d_i;
        if (!seq_i) begin
            has <= 1'b0;
        end
        if (latch && de_i) begin
            n_px <= n_px + 1;
            px <= px + 1;
            last_px <= d_i;
            has <= seq_i;
            if (stale || sync_on || jump) begin
                n_bad <= n_bad + 1;
            end
        end
        if (ls_on) begin
            if (px > 0) begin
                line_px <= px;
                ln <= ln + 1;
            end
            px <= 0;
        end
        if (fs_on) begin
            frame_lines <= ln;
            ln <= 0;
            n_frames <= n_frames + 1;
        end
    end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the colour panel port with a panel model.
// Assumes the header of port constants is on the include path.
`timescale 1ns/1ps
`include "tft_port_consts.vh"
module tb_top;
    typedef struct {
        logic [1:0] f;
        logic [1:0] l;
        logic cp;
        logic [31:0] p;
        logic [23:0] oe;
    } row_t;
    row_t rows [0:5] = '{
        '{2'h2, 2'h0, 1'b0, 32'h00a5c3e7, 24'hffffff},
        '{2'h2, 2'h1, 1'b1, 32'h00a5c3e7, 24'h03ffff},
        '{2'h2, 2'h2, 1'b0, 32'h00a5c3e7, 24'h00ffff},
        '{2'h0, 2'h0, 1'b1, 32'h0000f81f, 24'hffffff},
        '{2'h1, 2'h1, 1'b0, 32'h0003f03f, 24'h03ffff},
        '{2'h3, 2'h2, 1'b1, 32'h5a8143c7, 24'h00ffff}};
    // Short porches keep a frame near 360 core cycles
    logic [11:0] tv [0:7] = '{12'h004, 12'h003, 12'h002, 12'h001,
        12'h002, 12'h002, 12'h001, 12'h001};
    logic clk = 1'b0;
    logic pclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [15:0] reg_q;
    logic [31:0] pix = 32'h0;
    logic pix_ok = 1'b1;
    logic taken, pclk_pin, ls, ls_oe, fs, fs_oe, de;
    logic [23:0] bus, bus_oe, last_px;
    logic cpol = 1'b0;
    logic lpol = 1'b0;
    logic fpol = 1'b0;
    logic stream = 1'b0;
    logic [15:0] q;
    integer n_px, line_px, frame_lines, n_frames, n_bad, i, s;
    integer n_fail = 0;
    integer check_count = 0;
    // Released sync lines are pulled to their idle level
    wire ls_w = ls_oe ? ls : !lpol;
    wire fs_w = fs_oe ? fs : !fpol;

    tft_sync_display_port #(.CNT_W(12)) dut_u (
        .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
        .reg_rdata_o(reg_q), .pix_data_i(pix), .pix_valid_i(pix_ok),
        .pix_taken_o(taken), .panel_pixel_clock_i(pclk),
        .pixel_clock_pin_o(pclk_pin), .line_sync_pin_o(ls),
        .line_sync_oe_o(ls_oe), .frame_sync_pin_o(fs),
        .frame_sync_oe_o(fs_oe), .data_valid_pin_o(de),
        .colour_bus_o(bus), .colour_bus_oe_o(bus_oe));
    panel_model panel_u (
        .clk_i(clk), .pclk_i(pclk_pin), .ls_i(ls_w), .fs_i(fs_w),
        .de_i(de), .d_i(bus), .cpol_i(cpol), .lpol_i(lpol),
        .fpol_i(fpol), .seq_i(stream), .n_px(n_px), .last_px(last_px),
        .line_px(line_px), .frame_lines(frame_lines),
        .n_frames(n_frames), .n_bad(n_bad));

    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #37;
        forever #100 pclk = ~pclk;
    end
    // Source advances only after the port reports a pixel taken
    always @(posedge clk) begin
        if (taken && stream) begin
            pix <= pix + 32'h00010101;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task reg_wr(input [3:0] a, input [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task reg_rd(input [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = reg_q;
    endtask
    task chk_reg(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %h %h", $time, got, exp);
        end
    endtask
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %h %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Waits for n more frames (sel) or latched pixels, bounded
    task wait_cnt(input logic sel, input integer n);
        integer k, b;
        b = (sel ? n_frames : n_px) + n;
        for (k = 0; k < 3000 && (sel ? n_frames : n_px) < b; k++) begin
            @(posedge clk);
            #1;
        end
        if ((sel ? n_frames : n_px) < b) begin
            chk_val(k, 0);
            report_and_stop();
        end
    endtask
    function automatic [15:0] ctrlw(input [1:0] f, input [1:0] l,
        input cp, input lp, input fp, input su);
        ctrlw = {5'h0, f, l, su, cp, fp, lp, 2'h1, 1'b1};
    endfunction
    function automatic [23:0] narrow(input [31:0] p, input [1:0] f,
        input [1:0] l);
        logic [23:0] c;
        case (f)
            2'h0: c = {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
            2'h1: c = {p[17:12], 2'h0, p[11:6], 2'h0, p[5:0], 2'h0};
            default: c = p[23:0];
        endcase
        case (l)
            2'h1: narrow = {6'h0, c[23:18], c[15:10], c[7:2]};
            2'h2: narrow = {8'h0, c[23:19], c[15:10], c[7:3]};
            default: narrow = c;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        reg_rd(`REG_CTRL, q);
        chk_reg(q, `RST_CTRL);
        reg_rd(`REG_H_ACTIVE, q);
        chk_reg(q, {4'h0, `RST_H_ACTIVE});
        reg_rd(`REG_V_BACK, q);
        chk_reg(q, {4'h0, `RST_V_BACK});
        reg_rd(4'hc, q);
        chk_reg(q, 16'h0);
        reg_wr(`REG_CTRL, 16'h0);
        for (i = 0; i < 8; i++)
            reg_wr(4'(i + 1), {4'hf, tv[i]});
        for (i = 0; i < 8; i++) begin
            reg_rd(4'(i + 1), q);
            chk_reg(q, {4'h0, tv[i]});
        end
        for (i = 0; i < 6; i++) begin
            reg_wr(`REG_CTRL, 16'h0);
            pix <= rows[i].p;
            cpol <= rows[i].cp;
            reg_wr(`REG_CTRL, ctrlw(rows[i].f, rows[i].l, rows[i].cp,
                1'b0, 1'b0, 1'b1));
            wait_cnt(1'b0, 3);
            chk_val(last_px, narrow(rows[i].p, rows[i].f, rows[i].l));
            chk_val(bus_oe, rows[i].oe);
        end
        // Counting pixel stream, both sync polarities high
        reg_wr(`REG_CTRL, 16'h0);
        pix <= 32'h00102030;
        stream <= 1'b1;
        cpol <= 1'b1;
        lpol <= 1'b1;
        fpol <= 1'b1;
        reg_wr(`REG_CTRL, ctrlw(2'h2, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1));
        wait_cnt(1'b1, 3);
        chk_val(line_px, 4);
        chk_val(frame_lines, 2);
        // No syncs and a starved source
        stream <= 1'b0;
        reg_wr(`REG_CTRL, 16'h0);
        pix_ok <= 1'b0;
        cpol <= 1'b0;
        lpol <= 1'b0;
        fpol <= 1'b0;
        reg_wr(`REG_CTRL, ctrlw(2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        wait_cnt(1'b0, 2);
        chk_val({ls_oe, fs_oe}, 0);
        reg_rd(`REG_STATUS, q);
        chk_reg(q & 16'h0001, 16'h0001);
        reg_wr(`REG_CTRL, 16'h0);
        pix_ok <= 1'b1;
        reg_wr(`REG_STATUS, 16'h0001);
        reg_rd(`REG_STATUS, q);
        chk_reg(q & 16'h0001, 16'h0);
        // Monochrome class leaves the colour port idle
        reg_wr(`REG_CTRL, ctrlw(2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1) & 16'hfff9);
        s = n_px;
        repeat (400) @(posedge clk);
        #1;
        chk_val(bus_oe, 0);
        chk_val(n_px, s);
        chk_val(n_bad, 0);
        report_and_stop();
    end
endmodule
